// >>> awd_chk.sv
`timescale 1ns/1ns
// ****
// Bus and interrupt checks
// ****
module awd_chk (
	// Clock and reset
	input wire MCLK,
	input wire SRST,
	// Bus
	input wire HSEL,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire HREADY,
	input wire [31:0] HRDATA,
	input wire HREADYOUT,
	input wire HRESP,
	// Interrupts
	input wire [15:0] WDT_IRQ_LINE,
	input wire IRQ
);
	// Request taken this edge
	wire tk = HSEL && HTRANS[1] && HREADY;
	// Write data phase flag
	reg wph;
	always @(posedge MCLK)
		wph <= SRST ? 1'b0 : (tk && HWRITE);
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	chk_resp_okay: assert property (HRESP == 1'b0) else $error("bad response");
	chk_rd_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait");
	chk_wr_ready: assert property (tk && HWRITE |=> HREADYOUT) else $error("write wait");
	chk_wait_cause: assert property (!HREADYOUT |-> $past(tk && !HWRITE)) else $error("stray wait");
	chk_rdata_hi: assert property (HRDATA[31:8] == 24'h0) else $error("upper data");
	chk_map_bad: assert property (WDT_IRQ_LINE[2] == 1'b0 && WDT_IRQ_LINE[0] == 1'b0) else $error("bad line");
	chk_line_onehot: assert property ($onehot0(WDT_IRQ_LINE)) else $error("many lines");
	chk_line_clear: assert property ($fell(|WDT_IRQ_LINE) |-> $past(wph) || $past(SRST)) else $error("line fell");
	chk_rst_quiet: assert property (disable iff (1'b0) SRST |=> !IRQ && WDT_IRQ_LINE == 16'h0) else $error("reset irq");
endmodule // awd_chk
bind awd_watchdog awd_chk chk_u (.MCLK(MCLK), .SRST(SRST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WDT_IRQ_LINE(WDT_IRQ_LINE), .IRQ(IRQ));

// >>> awd_src_mdl.sv
`timescale 1ns/1ns
// ****
// Reload and trigger sources
// ****
module awd_src_mdl (
	// Clock
	input wire mclk,
	// Requests from bench
	input wire [3:0] go,
	// Source pins
	output reg [3:0] pin
);
	// Previous request
	reg [3:0] p1_reg = 4'h0;
	// Pulse is two cycles; a held trigger stays high
	always @(posedge mclk)
	begin
		p1_reg <= go;
		pin <= go | p1_reg;
	end
endmodule // awd_src_mdl

// >>> awd_watchdog.v
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
`include "awd_wdt_map.vh"

module awd_watchdog #(
	parameter [23:0] SEC_CYCLES = `AWD_SEC_CYCLES,
	parameter [5:0] SEC_PER_MIN = `AWD_SEC_PER_MIN
)(
	// Clock and reset
	input wire MCLK,
	input wire SRST,
	// AHB-Lite slave
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output wire [31:0] HRDATA,
	output wire HREADYOUT,
	output wire HRESP,
	// Reload and trigger sources
	input wire GAME_PORT_ACCESS,
	input wire KBD_IRQ,
	input wire MOUSE_IRQ,
	input wire KBC_OUTPUT_TRIGGER,
	// Interrupt outputs
	output wire [15:0] WDT_IRQ_LINE,
	output wire IRQ
);

	// ********************
	// Constants
	// ********************
	// One-hot watchdog states
	localparam [2:0] ST_OFF = 3'h1;
	localparam [2:0] ST_RUN = 3'h2;
	localparam [2:0] ST_EXP = 3'h4;
	// Input bit order in the synchroniser
	localparam SRC_GAME = 0;
	localparam SRC_KBD = 1;
	localparam SRC_MOUSE = 2;
	localparam SRC_KBC = 3;
	// Last prescaler and second counts
	localparam [23:0] SEC_LAST = SEC_CYCLES - 24'h000001;
	localparam [5:0] MIN_LAST = SEC_PER_MIN - 6'h01;

	// ********************
	// Declarations
	// ********************
	// Bus address phase capture
	reg a_write_reg;
	reg a_read_reg;
	reg [9:0] a_idx_reg;
	reg rd_done_reg;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;
	// Software registers
	reg units_sec_reg;
	reg [7:0] value_reg;
	reg [2:0] src_en_reg;
	reg [3:0] map_reg;
	reg kbc_en_reg;
	reg [1:0] ist_reg;
	reg [1:0] ist_next;
	reg [1:0] imask_reg;
	// Watchdog core
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] cnt_reg;
	reg [23:0] pre_reg;
	reg [5:0] sec_cnt_reg;
	reg [15:0] irq_line_reg;
	// Input synchroniser and edge stage
	reg [3:0] sync1_reg;
	reg [3:0] sync2_reg;
	reg [3:0] sync3_reg;
	// Decoded strobes
	wire addr_acc;
	wire wr_en;
	wire [7:0] wbyte;
	wire wr_value;
	wire wr_ctrl;
	wire [3:0] rise;
	wire force_sw;
	wire force_kbc;
	wire force_ev;
	wire set_sw;
	wire clr_sw;
	wire reload_src;
	wire reload_ev;
	wire sec_tick;
	wire min_tick;
	wire unit_tick;
	wire expire;
	wire run;
	wire flag;
	wire load;
	wire map_ok;

	// ********************
	// AHB-Lite slave
	// ********************
	// Transfer accepted in its address phase
	assign addr_acc = HSEL & HTRANS[1] & HREADY;

	// Address phase capture, held over waits
	always @(posedge MCLK)
	begin
		if (SRST)
		begin
			a_write_reg <= 1'b0;
			a_read_reg <= 1'b0;
			a_idx_reg <= 10'h000;
		end
		else if (HREADY)
		begin
			a_write_reg <= addr_acc & HWRITE;
			a_read_reg <= addr_acc & ~HWRITE;
			a_idx_reg <= HADDR[11:2];
		end
	end

	// Read takes one wait state so that a
	// write just before it is seen
	always @(posedge MCLK)
	begin
		if (SRST)
			rd_done_reg <= 1'b0;
		else if (HREADY)
			rd_done_reg <= 1'b0;
		else if (a_read_reg)
			rd_done_reg <= 1'b1;
	end

	// Read data sampled in the wait cycle
	always @(posedge MCLK)
	begin
		if (SRST)
			rdata_reg <= 32'h00000000;
		else if (a_read_reg & ~rd_done_reg)
			rdata_reg <= rdata_next;
	end

	// Bus answers; always OKAY
	assign HREADYOUT = ~(a_read_reg & ~rd_done_reg);
	assign HRESP = 1'b0;
	assign HRDATA = rdata_reg;

	// Writes land in the data phase
	assign wr_en = a_write_reg;
	assign wbyte = HWDATA[7:0];
	assign wr_value = wr_en & (a_idx_reg == `AWD_IDX_VALUE);
	assign wr_ctrl = wr_en & (a_idx_reg == `AWD_IDX_CTRL);

	// ********************
	// Read multiplexer
	// ********************
	// Unmapped indices read zero
	always @*
	begin
		rdata_next = 32'h00000000;
		case (a_idx_reg)
			// Logical device number, read only
			`AWD_IDX_LDN:
				rdata_next[7:0] = `AWD_LDN;
			// Only the units bit is stored
			`AWD_IDX_UNITS:
				rdata_next[`AWD_UNITS_SEC_BIT] = units_sec_reg;
			`AWD_IDX_VALUE:
				rdata_next[7:0] = value_reg;
			// Bit three reads zero
			`AWD_IDX_CFG:
			begin
				rdata_next[2:0] = src_en_reg;
				rdata_next[7:4] = map_reg;
			end
			// Force reads zero, upper bits zero
			`AWD_IDX_CTRL:
			begin
				rdata_next[`AWD_CTRL_STAT_BIT] = flag;
				rdata_next[`AWD_CTRL_KBCEN_BIT] = kbc_en_reg;
			end
			`AWD_IDX_ISTAT:
				rdata_next[1:0] = ist_reg;
			`AWD_IDX_IMASK:
				rdata_next[1:0] = imask_reg;
			default:
				rdata_next = 32'h00000000;
		endcase
	end

	// ********************
	// Configuration registers
	// ********************
	// Writable fields; all cleared by reset
	always @(posedge MCLK)
	begin
		if (SRST)
		begin
			units_sec_reg <= 1'b0;
			value_reg <= `AWD_RST_BYTE;
			src_en_reg <= 3'h0;
			map_reg <= `AWD_RST_MAP;
			kbc_en_reg <= 1'b0;
			imask_reg <= 2'h0;
		end
		else if (wr_en)
		begin
			case (a_idx_reg)
				// Reserved bits are dropped
				`AWD_IDX_UNITS:
					units_sec_reg <= wbyte[`AWD_UNITS_SEC_BIT];
				`AWD_IDX_VALUE:
					value_reg <= wbyte;
				`AWD_IDX_CFG:
				begin
					src_en_reg <= wbyte[2:0];
					map_reg <= wbyte[`AWD_CFG_MAP_HI:`AWD_CFG_MAP_LO];
				end
				// Upper bits expected zero, ignored
				`AWD_IDX_CTRL:
					kbc_en_reg <= wbyte[`AWD_CTRL_KBCEN_BIT];
				`AWD_IDX_IMASK:
					imask_reg <= wbyte[1:0];
				default:
					imask_reg <= imask_reg;
			endcase
		end
	end

	// ********************
	// Input synchroniser
	// ********************
	// Two flops, then one more for edges
	always @(posedge MCLK)
	begin
		if (SRST)
		begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
		end
		else
		begin
			sync1_reg <= {KBC_OUTPUT_TRIGGER, MOUSE_IRQ,
				KBD_IRQ, GAME_PORT_ACCESS};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Rising edges; pulse ends by itself
	// even if the source stays high
	assign rise = sync2_reg & ~sync3_reg;

	// ********************
	// Event decode
	// ********************
	// Reload sources, each gated by its enable
	assign reload_src =
		(rise[SRC_GAME] & src_en_reg[`AWD_CFG_GAME_BIT]) |
		(rise[SRC_KBD] & src_en_reg[`AWD_CFG_KBD_BIT]) |
		(rise[SRC_MOUSE] & src_en_reg[`AWD_CFG_MOUSE_BIT]);
	// A value write restarts as well
	assign reload_ev = reload_src | wr_value;

	// Software force is a one-cycle strobe,
	// never stored, so it reads back zero
	assign force_sw = wr_ctrl & wbyte[`AWD_CTRL_FORCE_BIT];
	// Trigger edge only when enabled
	assign force_kbc = rise[SRC_KBC] & kbc_en_reg;
	assign force_ev = force_sw | force_kbc;

	// Status bit writes
	assign set_sw = wr_ctrl & wbyte[`AWD_CTRL_STAT_BIT];
	assign clr_sw = wr_ctrl & ~wbyte[`AWD_CTRL_STAT_BIT];

	// ********************
	// Time base
	// ********************
	assign run = state_reg[1];
	assign flag = state_reg[2];

	// One-cycle second and minute enables
	assign sec_tick = run & (pre_reg == SEC_LAST);
	assign min_tick = sec_tick & (sec_cnt_reg == MIN_LAST);
	// Unit selected by the units bit
	assign unit_tick = units_sec_reg ? sec_tick : min_tick;

	// Counted expiry on the last unit
	assign expire = unit_tick & (cnt_reg == 8'h01);

	// Prescaler restarts with every load
	always @(posedge MCLK)
	begin
		if (SRST)
		begin
			pre_reg <= 24'h000000;
			sec_cnt_reg <= 6'h00;
		end
		else if (load | ~run)
		begin
			pre_reg <= 24'h000000;
			sec_cnt_reg <= 6'h00;
		end
		else if (sec_tick)
		begin
			pre_reg <= 24'h000000;
			if (min_tick)
				sec_cnt_reg <= 6'h00;
			else
				sec_cnt_reg <= sec_cnt_reg + 6'h01;
		end
		else
			pre_reg <= pre_reg + 24'h000001;
	end

	// ********************
	// Watchdog state machine
	// ********************
	// Next state from events and value
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			// Zero value: no counted expiry
			ST_OFF:
			begin
				if (force_ev | set_sw)
					state_next = ST_EXP;
				else if (value_reg != 8'h00)
					state_next = ST_RUN;
			end
			ST_RUN:
			begin
				if (force_ev | set_sw | expire)
					state_next = ST_EXP;
				else if (value_reg == 8'h00)
					state_next = ST_OFF;
			end
			// A force wins over a clear in the same cycle
			ST_EXP:
			begin
				if (clr_sw & ~force_ev)
				begin
					if (value_reg != 8'h00)
						state_next = ST_RUN;
					else
						state_next = ST_OFF;
				end
			end
			default:
				state_next = ST_OFF;
		endcase
	end

	// State register
	always @(posedge MCLK)
	begin
		if (SRST)
			state_reg <= ST_OFF;
		else
			state_reg <= state_next;
	end

	// Load on entering run or on a reload
	assign load = state_next[1] & (~run | reload_ev);

	// Remaining units; a value being written
	// loads straight from the bus, not the old copy
	always @(posedge MCLK)
	begin
		if (SRST)
			cnt_reg <= 8'h00;
		else if (load)
			cnt_reg <= wr_value ? wbyte : value_reg;
		else if (run & unit_tick)
			cnt_reg <= cnt_reg - 8'h01;
	end

	// ********************
	// Interrupts
	// ********************
	// Routing value usable unless off or invalid
	assign map_ok = (map_reg != `AWD_MAP_OFF) & (map_reg != `AWD_MAP_BAD);

	// Status flag drives the routed line
	always @(posedge MCLK)
	begin
		if (SRST)
			irq_line_reg <= 16'h0000;
		else if (state_next[2] & map_ok)
			irq_line_reg <= 16'h0001 << map_reg;
		else
			irq_line_reg <= 16'h0000;
	end
	assign WDT_IRQ_LINE = irq_line_reg;

	// Sticky events, write one to clear
	always @*
	begin
		ist_next = ist_reg;
		if (wr_en & (a_idx_reg == `AWD_IDX_ISTAT))
			ist_next = ist_reg & ~wbyte[1:0];
		// Setting beats the clear
		if (state_next[2] & ~flag)
			ist_next[`AWD_IST_TIMEOUT_BIT] = 1'b1;
		if (run & reload_src)
			ist_next[`AWD_IST_RELOAD_BIT] = 1'b1;
	end

	// Interrupt status register
	always @(posedge MCLK)
	begin
		if (SRST)
			ist_reg <= 2'h0;
		else
			ist_reg <= ist_next;
	end

	// Level output while unmasked bit set
	assign IRQ = |(ist_reg & imask_reg);

endmodule // awd_watchdog

// >>> awd_wdt_map.vh
`ifndef AWD_WDT_MAP_VH
`define AWD_WDT_MAP_VH

// ********************
// Register indices
// ********************
// Byte address is four times the index
`define AWD_IDX_LDN 10'h0F0
`define AWD_IDX_UNITS 10'h0F1
`define AWD_IDX_VALUE 10'h0F2
`define AWD_IDX_CFG 10'h0F3
`define AWD_IDX_CTRL 10'h0F4
`define AWD_IDX_ISTAT 10'h0F5
`define AWD_IDX_IMASK 10'h0F6

// ********************
// Field positions
// ********************
`define AWD_UNITS_SEC_BIT 7
`define AWD_CFG_GAME_BIT 0
`define AWD_CFG_KBD_BIT 1
`define AWD_CFG_MOUSE_BIT 2
`define AWD_CFG_MAP_HI 7
`define AWD_CFG_MAP_LO 4
`define AWD_CTRL_STAT_BIT 0
`define AWD_CTRL_FORCE_BIT 2
`define AWD_CTRL_KBCEN_BIT 3
`define AWD_IST_TIMEOUT_BIT 0
`define AWD_IST_RELOAD_BIT 1

// ********************
// Reset and fixed values
// ********************
`define AWD_RST_BYTE 8'h00
`define AWD_RST_MAP 4'h0
`define AWD_LDN 8'h08
`define AWD_MAP_OFF 4'h0
`define AWD_MAP_BAD 4'h2

// ********************
// Timing
// ********************
`define AWD_CLK_NS 100
`define AWD_SEC_NS 1000000000
// One second of 100 ns cycles, sized to the prescaler
`define AWD_SEC_CYCLES 24'h989680
`define AWD_SEC_PER_MIN 6'h3C

`endif

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
	// ****
	// Setup
	// ****
	localparam S = 10;
	localparam M = 3;
	localparam [31:0] A_LDN = 32'h3C0, A_UNI = 32'h3C4, A_VAL = 32'h3C8, A_CFG = 32'h3CC;
	localparam [31:0] A_CTL = 32'h3D0, A_IST = 32'h3D4, A_MSK = 32'h3D8;
	reg MCLK = 1'b0;
	reg SRST = 1'b1;
	reg [31:0] HADDR = 32'h0, HWDATA = 32'h0, rv;
	reg [1:0] HTRANS = 2'h0;
	reg HWRITE = 1'b0;
	reg [3:0] go = 4'h0;
	wire [31:0] HRDATA;
	wire HREADYOUT, HRESP, IRQ;
	wire [15:0] WDT_IRQ_LINE;
	wire [3:0] pin;
	integer miscompares = 0, n_checks = 0, i, n, v;
	initial
	begin
		forever #50 MCLK = ~MCLK;
	end
	awd_watchdog #(.SEC_CYCLES(24'h00000A), .SEC_PER_MIN(6'h03)) dut_u (.MCLK(MCLK), .SRST(SRST), .HSEL(1'b1),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GAME_PORT_ACCESS(pin[0]), .KBD_IRQ(pin[1]),
		.MOUSE_IRQ(pin[2]), .KBC_OUTPUT_TRIGGER(pin[3]), .WDT_IRQ_LINE(WDT_IRQ_LINE), .IRQ(IRQ));
	awd_src_mdl src_u (.mclk(MCLK), .go(go), .pin(pin));
	// ****
	// Tasks
	// ****
	function integer exp_cyc(input integer val, input integer sec);
		exp_cyc = val * S * (sec ? 1 : M);
	endfunction
	task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
	begin
		n_checks = n_checks + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("[ERR] %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	// Wait for ready, bounded
	task bw;
		integer k;
	begin
		k = 0;
		@(posedge MCLK);
		while (HREADYOUT !== 1'b1 && k < 20)
		begin
			k = k + 1;
			@(posedge MCLK);
		end
		if (k >= 20)
		begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end
	endtask
	task wr(input [31:0] a, input [7:0] d);
	begin
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= 1'b1;
		bw;
		HTRANS <= 2'h0;
		HWDATA <= {24'h0, d};
		bw;
	end
	endtask
	task rd(input [31:0] a);
	begin
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= 1'b0;
		bw;
		HTRANS <= 2'h0;
		bw;
		rv = HRDATA;
	end
	endtask
	// Cycles until interrupt
	task tmo;
	begin
		n = 0;
		while (IRQ !== 1'b1 && n < 400)
		begin
			@(posedge MCLK);
			n = n + 1;
		end
		if (n >= 400)
		begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end
	endtask
	task clr;
	begin
		wr(A_VAL, 8'h00);
		wr(A_CTL, 8'h00);
		wr(A_IST, 8'h03);
		@(posedge MCLK);
	end
	endtask
	task pul(input integer s, input integer k);
	begin
		repeat (k)
		begin
			repeat (9) @(posedge MCLK);
			go[s] <= 1'b1;
			@(posedge MCLK);
			go[s] <= 1'b0;
		end
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// ****
	// Scenarios
	// ****
	initial
	begin
		v = $urandom(50);
		repeat (4) @(posedge MCLK);
		SRST <= 1'b0;
		@(posedge MCLK);
		rd(A_LDN);
		chk("ldn", 32'h8, rv);
		for (i = 1; i < 5; i = i + 1)
		begin
			rd(A_LDN + 4 * i);
			chk("rstval", 32'h0, rv);
		end
		v = $urandom;
		wr(A_UNI, v[7:0]);
		rd(A_UNI);
		chk("units", v & 32'h80, rv);
		$display("done: registers");
		wr(A_MSK, 8'h01);
		wr(A_CFG, 8'h30);
		for (i = 0; i < 2; i = i + 1)
		begin
			v = 1 + $urandom % 4;
			wr(A_UNI, i ? 8'h00 : 8'h80);
			wr(A_VAL, 8'hFF);
			wr(A_VAL, v[7:0]);
			tmo;
			chk("expiry", 1, n >= exp_cyc(v, !i) - 3 && n <= exp_cyc(v, !i) + 3);
			chk("line", 32'h8, WDT_IRQ_LINE);
			rd(A_CTL);
			chk("status", 32'h1, rv);
			clr;
			chk("irqoff", 32'h0, {IRQ, WDT_IRQ_LINE});
		end
		wr(A_VAL, 8'h01);
		wr(A_VAL, 8'h00);
		repeat (100) @(posedge MCLK);
		chk("zero", 32'h0, IRQ);
		$display("done: counting");
		wr(A_UNI, 8'h80);
		for (i = 0; i < 3; i = i + 1)
		begin
			wr(A_CFG, 8'h30 | (8'h01 << i));
			wr(A_VAL, 8'h03);
			pul(i, 6);
			rd(A_CTL);
			chk("reload", 32'h0, rv);
			rd(A_IST);
			chk("ireload", 32'h2, rv);
			wr(A_CFG, 8'h30);
			pul(i, 4);
			rd(A_CTL);
			chk("ignored", 32'h1, rv);
			clr;
		end
		$display("done: reload");
		for (i = 0; i < 5; i = i + 1)
		begin
			v = (32'h0F5310 >> (4 * i)) & 15;
			wr(A_CFG, v << 4);
			wr(A_CTL, 8'h04);
			rd(A_CTL);
			chk("force", 32'h1, rv);
			chk("map", (v == 0 || v == 2) ? 0 : 1 << v, WDT_IRQ_LINE);
			clr;
		end
		wr(A_CTL, 8'h01);
		rd(A_CTL);
		chk("stwr", 32'h1, rv);
		clr;
		$display("done: force");
		wr(A_CTL, 8'h08);
		go[3] <= 1'b1;
		repeat (5) @(posedge MCLK);
		rd(A_CTL);
		chk("trig", 32'h9, rv);
		wr(A_CTL, 8'h08);
		repeat (5) @(posedge MCLK);
		rd(A_CTL);
		chk("level", 32'h8, rv);
		go[3] <= 1'b0;
		wr(A_CTL, 8'h00);
		pul(3, 1);
		repeat (5) @(posedge MCLK);
		rd(A_CTL);
		chk("trigoff", 32'h0, rv);
		$display("done: trigger");
		wr(A_VAL, 8'h05);
		wr(A_CFG, 8'h3F);
		wr(A_CTL, 8'h0C);
		SRST <= 1'b1;
		repeat (2) @(posedge MCLK);
		SRST <= 1'b0;
		@(posedge MCLK);
		for (i = 1; i < 5; i = i + 1)
		begin
			rd(A_LDN + 4 * i);
			chk("rst2", 32'h0, rv);
		end
		$display("done: reset");
		end_of_test;
	end
endmodule // tb_top
